/* design/cise_pkg.sv */
// Constants and types shared by the instruction execution core
package cise_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int CLKS_PER_CYCLE  = 4;
  localparam logic [1:0] PHASE_LAST = 2'(CLKS_PER_CYCLE - 1);

  // ----------------------------------------------------------------
  // Data memory and program counter geometry
  // ----------------------------------------------------------------
  localparam int DM_DEPTH        = 256;
  localparam int SECTOR_BITS     = 7;
  localparam int PC_W            = 13;
  localparam int STACK_DEPTH     = 8;
  localparam logic [7:0] PCL_ADDR   = 8'h07;
  localparam logic [4:0] LAST_PAGE  = 5'h1F;

  // ----------------------------------------------------------------
  // Register port offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_ACC    = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_TABLE_POINTER   = 2'h2;
  localparam logic [1:0] REG_TABLE_HIGH_BYTE   = 2'h3;
  localparam logic [7:0] ACC_RST    = 8'h00;

  // Status bit positions
  localparam int ST_C   = 0;
  localparam int ST_AC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_OV  = 3;
  localparam int ST_SC  = 4;
  localparam int ST_CZ  = 5;
  localparam int ST_PDF = 6;
  localparam int ST_TO  = 7;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADC = 6'h02, OP_SUB = 6'h03,
    OP_SBC = 6'h04, OP_DAA = 6'h05, OP_AND = 6'h06, OP_OR  = 6'h07,
    OP_XOR = 6'h08, OP_CPL = 6'h09, OP_INC = 6'h0A, OP_DEC = 6'h0B,
    OP_RR  = 6'h0C, OP_RRC = 6'h0D, OP_RL  = 6'h0E, OP_RLC = 6'h0F,
    OP_MOVAM = 6'h10, OP_MOVMA = 6'h11, OP_CLRB = 6'h12,
    OP_SETB  = 6'h13, OP_CLRM  = 6'h14, OP_SETM = 6'h15,
    OP_SWAP  = 6'h16, OP_JMP   = 6'h17, OP_CALL = 6'h18,
    OP_RET   = 6'h19, OP_RETAX = 6'h1A, OP_INTERRUPT_RETURN_OP = 6'h1B,
    OP_SZ    = 6'h1C, OP_SNZ   = 6'h1D, OP_SZB  = 6'h1E,
    OP_SNZB  = 6'h1F, OP_SZA   = 6'h20, OP_SIZ  = 6'h21,
    OP_SDZ   = 6'h22, OP_TRD   = 6'h23, OP_TRDL = 6'h24,
    OP_ITRD  = 6'h25, OP_ITRDL = 6'h26, OP_CLRWDT = 6'h27,
    OP_HALT  = 6'h28
  } cise_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } cise_state_t;

endpackage

/* design/cise_core.sv */
// Instruction execution core of an 8-bit accumulator machine
// Operation
// - Basic memory operands reach only sector 0 directly
// - Additions take one cycle, update Z C AC OV SC
// - Subtractions take one cycle, update Z C AC OV SC CZ
// - Decimal adjust corrects accumulator into memory, alters carry only
// - AND OR XOR complement take one cycle, zero flag only
// - Increment and decrement by one, zero flag only
// - Plain rotates keep flags; through-carry rotates change carry only
// - Accumulator variants keep memory; memory variants write back
// - Bit set and clear touch one bit; moves keep flags
// - Jump, call and returns take two cycles, no flags
// - Skips take one cycle untaken, up to three taken
// - Skip-on-increment/decrement adjusts then skips on zero
// - Writing the program counter low byte costs two cycles
// - Watchdog clear clears timeout and power-down flags
// - Halt takes one cycle and enters power-down
// - Table reads take two cycles, high byte to table-high
// - Incrementing table reads bump the pointer before fetching
// - Nibble swap exchanges halves, no flags changed
// - Long-address forms reach any sector, take two cycles
// - One instruction cycle is four system clocks
`timescale 1ns/1ps
module cise_core
  import cise_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Instruction issue
  input  wire logic              instrValid,
  output logic                   instrReady,
  input  wire cise_op_t          opCode,
  input  wire logic              opToAcc,
  input  wire logic              opImm,
  input  wire logic              opLong,
  input  wire logic [7:0]        opAddr,
  input  wire logic [7:0]        opData,
  input  wire logic [2:0]        opBit,
  input  wire logic [PC_W-1:0]   opTarget,
  output logic                   instrDone,
  // Program memory read port
  output logic                   progRd,
  output logic [PC_W-1:0]        progAddr,
  input  wire logic [15:0]       progData,
  // Core status
  output logic [PC_W-1:0]        pcOut,
  output logic                   powerDown,
  output logic                   intEnable,
  input  wire logic              wdtTimeout,
  input  wire logic              wakeUp,
  // Register port
  input  wire logic [1:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [7:0]             regRdData
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cise_state_t           state_r;
  cise_op_t              op_r;
  logic                  toAcc_r, imm_r, long_r;
  logic [7:0]            addr_r, data_r;
  logic [2:0]            bit_r;
  logic [PC_W-1:0]       target_r, pc_r, progAddr_r;
  logic [1:0]            phase_r, cyc_r;
  logic [7:0]            dmem [DM_DEPTH];
  logic [PC_W-1:0]       stack [STACK_DEPTH];
  logic [2:0]            sp_r;
  logic [7:0]            acc_r, table_pointer_r, table_high_byte_r, prog_r, regRdData_r;
  logic                  c_r, ac_r, z_r, ov_r, sc_r, cz_r, to_r, pdf_r;
  logic                  pd_r, emi_r, progRd_r;
  logic [3:0]            clkCnt_r;

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  logic [7:0] effAddr, memVal, bOp, bAlu;
  // Short forms fold onto sector 0
  assign effAddr = long_r ? addr_r : {1'b0, addr_r[SECTOR_BITS-1:0]};
  assign memVal  = (effAddr == PCL_ADDR) ? pc_r[7:0] : dmem[effAddr];
  assign bOp     = imm_r ? data_r : memVal;

  function automatic logic isSubOp(input cise_op_t o);
    isSubOp = (o == OP_SUB) || (o == OP_SBC);
  endfunction

  function automatic logic isTableOp(input cise_op_t o);
    isTableOp = (o == OP_TRD) || (o == OP_TRDL) ||
                (o == OP_ITRD) || (o == OP_ITRDL);
  endfunction

  // ----------------------------------------------------------------
  // Adder
  // ----------------------------------------------------------------
  logic       cin, isSub, isTbl, tblPre, tblLast;
  logic [8:0] sum9;
  logic [4:0] nib5;
  assign isSub  = isSubOp(op_r);
  assign isTbl  = isTableOp(op_r);
  assign bAlu   = isSub ? ~bOp : bOp;
  assign cin    = (op_r == OP_SUB) ? 1'b1 :
                  ((op_r == OP_ADC) || (op_r == OP_SBC)) ? c_r : 1'b0;
  assign sum9   = {1'b0, acc_r} + {1'b0, bAlu} + {8'h00, cin};
  assign nib5   = {1'b0, acc_r[3:0]} + {1'b0, bAlu[3:0]} + {4'h0, cin};

  // Decimal adjust
  logic       lowAdj, highAdj;
  logic [8:0] daa1, daa2;
  assign lowAdj  = (acc_r[3:0] > 4'h9) || ac_r;
  assign daa1    = {1'b0, acc_r} + (lowAdj ? 9'h006 : 9'h000);
  assign highAdj = daa1[8] || (daa1[7:4] > 4'h9) || c_r;
  assign daa2    = daa1 + (highAdj ? 9'h060 : 9'h000);

  // Table fetch address
  logic [7:0] tblpEff;
  assign tblPre  = (op_r == OP_ITRD) || (op_r == OP_ITRDL);
  assign tblLast = (op_r == OP_TRDL) || (op_r == OP_ITRDL);
  assign tblpEff = tblPre ? table_pointer_r + 8'h01 : table_pointer_r;

  // ----------------------------------------------------------------
  // Result and flag selection
  // ----------------------------------------------------------------
  logic [7:0] res;
  logic       wrRes, toAccEff, updZ, updC, updArith, skip;
  logic       cN, acN, ovN, scN, czN;

  always_comb
  begin
    res = memVal;
    wrRes = 1'b0;
    toAccEff = toAcc_r | imm_r;
    updZ = 1'b0;
    updC = 1'b0;
    updArith = 1'b0;
    skip = 1'b0;
    cN = c_r;
    acN = ac_r;
    ovN = ov_r;
    czN = cz_r;
    case (op_r)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC:
      begin
        res = sum9[7:0];
        wrRes = 1'b1;
        updZ = 1'b1;
        updArith = 1'b1;
        cN = sum9[8];
        acN = nib5[4];
        ovN = (acc_r[7] == bAlu[7]) && (sum9[7] != acc_r[7]);
        czN = (op_r == OP_SBC) ? (cz_r & (sum9[7:0] == 8'h00))
                               : (sum9[7:0] == 8'h00);
      end
      OP_DAA:
      begin
        res = daa2[7:0];
        wrRes = 1'b1;
        toAccEff = 1'b0;
        updC = 1'b1;
        cN = highAdj;
      end
      OP_AND, OP_OR, OP_XOR:
      begin
        res = (op_r == OP_AND) ? (acc_r & bOp) :
              (op_r == OP_OR)  ? (acc_r | bOp) : (acc_r ^ bOp);
        wrRes = 1'b1;
        updZ = 1'b1;
      end
      OP_CPL:
      begin
        res = ~memVal;
        wrRes = 1'b1;
        updZ = 1'b1;
      end
      OP_INC, OP_DEC:
      begin
        res = (op_r == OP_INC) ? memVal + 8'h01 : memVal - 8'h01;
        wrRes = 1'b1;
        updZ = 1'b1;
      end
      OP_RR:
      begin
        res = {memVal[0], memVal[7:1]};
        wrRes = 1'b1;
      end
      OP_RL:
      begin
        res = {memVal[6:0], memVal[7]};
        wrRes = 1'b1;
      end
      OP_RRC:
      begin
        res = {c_r, memVal[7:1]};
        wrRes = 1'b1;
        updC = 1'b1;
        cN = memVal[0];
      end
      OP_RLC:
      begin
        res = {memVal[6:0], c_r};
        wrRes = 1'b1;
        updC = 1'b1;
        cN = memVal[7];
      end
      OP_MOVAM:
      begin
        res = bOp;
        wrRes = 1'b1;
        toAccEff = 1'b1;
      end
      OP_MOVMA:
      begin
        res = acc_r;
        wrRes = 1'b1;
        toAccEff = 1'b0;
      end
      OP_CLRB, OP_SETB:
      begin
        res = memVal;
        res[bit_r] = (op_r == OP_SETB);
        wrRes = 1'b1;
        toAccEff = 1'b0;
      end
      OP_CLRM, OP_SETM:
      begin
        res = (op_r == OP_SETM) ? 8'hFF : 8'h00;
        wrRes = 1'b1;
        toAccEff = 1'b0;
      end
      OP_SWAP:
      begin
        res = {memVal[3:0], memVal[7:4]};
        wrRes = 1'b1;
      end
      OP_RETAX:
      begin
        res = data_r;
        wrRes = 1'b1;
        toAccEff = 1'b1;
      end
      OP_SZ, OP_SNZ:
        skip = (memVal == 8'h00) ^ (op_r == OP_SNZ);
      OP_SZB, OP_SNZB:
        skip = memVal[bit_r] ^ (op_r == OP_SZB);
      OP_SZA:
      begin
        wrRes = 1'b1;
        toAccEff = 1'b1;
        skip = (memVal == 8'h00);
      end
      OP_SIZ, OP_SDZ:
      begin
        res = (op_r == OP_SIZ) ? memVal + 8'h01 : memVal - 8'h01;
        wrRes = 1'b1;
        skip = (res == 8'h00);
      end
      OP_TRD, OP_TRDL, OP_ITRD, OP_ITRDL:
      begin
        res = prog_r;
        wrRes = 1'b1;
        toAccEff = 1'b0;
      end
      default:
        wrRes = 1'b0;
    endcase
  end

  assign scN = ovN ^ res[7];

  // ----------------------------------------------------------------
  // Cycle accounting
  // ----------------------------------------------------------------
  logic memWe, accWe, pclWr, isBranch, doneNow;
  logic [1:0] lastCyc;
  assign memWe    = wrRes && !toAccEff && (effAddr != PCL_ADDR);
  assign accWe    = wrRes && toAccEff;
  assign pclWr    = wrRes && !toAccEff && (effAddr == PCL_ADDR);
  assign isBranch = (op_r == OP_JMP) || (op_r == OP_CALL) ||
                    (op_r == OP_RET) || (op_r == OP_RETAX) ||
                    (op_r == OP_INTERRUPT_RETURN_OP);
  // Two-cycle forms plus one more when the next word is skipped
  assign lastCyc  = {1'b0, isBranch | isTbl | long_r | pclWr} +
                    {1'b0, skip};
  assign doneNow  = (state_r == ST_EXEC) && (phase_r == PHASE_LAST) &&
                    (cyc_r == lastCyc);

  assign instrReady = (state_r == ST_IDLE) && !pd_r;
  assign instrDone  = doneNow;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r  <= ST_IDLE;
      phase_r  <= 2'h0;
      cyc_r    <= 2'h0;
      clkCnt_r <= 4'h0;
    end
    else if (instrValid && instrReady)
    begin
      state_r  <= ST_EXEC;
      phase_r  <= 2'h0;
      cyc_r    <= 2'h0;
      clkCnt_r <= 4'h0;
    end
    else if (state_r == ST_EXEC)
    begin
      phase_r  <= phase_r + 2'h1;
      clkCnt_r <= clkCnt_r + 4'h1;
      if (phase_r == PHASE_LAST)
        cyc_r <= cyc_r + 2'h1;
      if (doneNow)
        state_r <= ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (instrValid && instrReady)
    begin
      op_r     <= opCode;
      toAcc_r  <= opToAcc;
      imm_r    <= opImm;
      long_r   <= opLong;
      addr_r   <= opAddr;
      data_r   <= opData;
      bit_r    <= opBit;
      target_r <= opTarget;
    end
  end

  // Program memory fetch in the first clock of a table read
  logic fetchNow;
  assign fetchNow = (state_r == ST_EXEC) && isTbl &&
                    (cyc_r == 2'h0) && (phase_r == 2'h0);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      progRd_r   <= 1'b0;
      progAddr_r <= '0;
      prog_r     <= 8'h00;
      table_high_byte_r     <= 8'h00;
    end
    else
    begin
      progRd_r <= fetchNow;
      if (fetchNow)
        progAddr_r <= {tblLast ? LAST_PAGE : data_r[4:0], tblpEff};
      if (progRd_r)
      begin
        prog_r <= progData[7:0];
        table_high_byte_r <= progData[15:8];
      end
    end
  end
  assign progRd   = progRd_r;
  assign progAddr = progAddr_r;

  // ----------------------------------------------------------------
  // Commit: memory, accumulator, flags, program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
    if (doneNow && memWe)
      dmem[effAddr] <= res;

  logic [PC_W-1:0] pcInc;
  assign pcInc = pc_r + (skip ? PC_W'(2) : PC_W'(1));

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      acc_r <= ACC_RST;
      table_pointer_r <= 8'h00;
      pc_r <= '0;
      sp_r <= 3'h0;
      emi_r <= 1'b0;
    end
    else if (doneNow)
    begin
      if (accWe)
        acc_r <= res;
      if (tblPre)
        table_pointer_r <= tblpEff;
      case (op_r)
        OP_JMP:
          pc_r <= target_r;
        OP_CALL:
        begin
          stack[sp_r] <= pc_r + PC_W'(1);
          sp_r <= sp_r + 3'h1;
          pc_r <= target_r;
        end
        OP_RET, OP_RETAX, OP_INTERRUPT_RETURN_OP:
        begin
          sp_r <= sp_r - 3'h1;
          pc_r <= stack[sp_r - 3'h1];
          if (op_r == OP_INTERRUPT_RETURN_OP)
            emi_r <= 1'b1;
        end
        default:
          pc_r <= pclWr ? {pc_r[PC_W-1:8], res} : pcInc;
      endcase
    end
    else if (regWr && state_r == ST_IDLE)
    begin
      if (regAddr == REG_ACC)
        acc_r <= regWrData;
      if (regAddr == REG_TABLE_POINTER)
        table_pointer_r <= regWrData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      {c_r, ac_r, z_r, ov_r, sc_r, cz_r} <= 6'h00;
    end
    else if (doneNow)
    begin
      if (updZ)
        z_r <= (res == 8'h00);
      if (updC || updArith)
        c_r <= cN;
      if (updArith)
      begin
        ac_r <= acN;
        ov_r <= ovN;
        sc_r <= scN;
        if (isSub)
          cz_r <= czN;
      end
    end
  end

  // Timeout set by the watchdog wins over a clear
  logic clrWdtNow, haltNow;
  assign clrWdtNow = doneNow && (op_r == OP_CLRWDT);
  assign haltNow   = doneNow && (op_r == OP_HALT);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      to_r <= 1'b0;
      pdf_r <= 1'b0;
      pd_r <= 1'b0;
    end
    else
    begin
      to_r  <= wdtTimeout | (to_r & !clrWdtNow & !haltNow);
      pdf_r <= haltNow | (pdf_r & !clrWdtNow);
      pd_r  <= haltNow | (pd_r & !wakeUp);
    end
  end

  assign pcOut     = pc_r;
  assign powerDown = pd_r;
  assign intEnable = emi_r;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [7:0] statusVal, regSel;
  assign statusVal = {to_r, pdf_r, cz_r, sc_r, ov_r, z_r, ac_r, c_r};
  assign regSel = (regAddr == REG_ACC)    ? acc_r :
                  (regAddr == REG_STATUS) ? statusVal :
                  (regAddr == REG_TABLE_POINTER)   ? table_pointer_r : table_high_byte_r;

  always_ff @(posedge clk_sys)
    if (sys_rst)
      regRdData_r <= 8'h00;
    else
      regRdData_r <= regRd ? regSel : 8'h00;
  assign regRdData = regRdData_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SECTOR0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == ST_EXEC && !long_r) |-> (effAddr[7] == 1'b0))
    else $error("short operand left sector 0");
  AST_ADD_ONE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && (op_r == OP_ADD) && !long_r && !pclWr) |-> clkCnt_r == 4'h3)
    else $error("add did not take one cycle");
  AST_SUB_CZ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && op_r == OP_SUB) |=> (cz_r == z_r))
    else $error("subtract cumulative zero wrong");
  AST_LOGIC_C: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && (op_r == OP_AND || op_r == OP_XOR)) |=> $stable(c_r) &&
      $stable(ov_r) && $stable(ac_r))
    else $error("logic op changed a flag other than zero");
  AST_ROT_FLAGS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && (op_r == OP_RR || op_r == OP_RL)) |=> $stable(statusVal))
    else $error("plain rotate changed a flag");
  AST_ACC_KEEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && toAcc_r && op_r != OP_DAA && !isTbl &&
      !(op_r inside {OP_MOVMA, OP_CLRB, OP_SETB, OP_CLRM, OP_SETM}))
      |-> !memWe)
    else $error("accumulator variant wrote memory");
  AST_JMP_TWO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && isBranch) |-> (clkCnt_r == 4'h7))
    else $error("branch did not take two cycles");
  AST_SKIP_ONE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && op_r == OP_SZ && !skip && !long_r) |-> clkCnt_r == 4'h3)
    else $error("untaken skip not one cycle");
  AST_CLRWDT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clrWdtNow && !wdtTimeout) |=> (!to_r && !pdf_r))
    else $error("watchdog clear left flags set");
  AST_HALT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    haltNow |=> (pd_r && pdf_r && !instrReady))
    else $error("halt did not power down");
  AST_TBL_TWO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fetchNow |=> progRd ##1 (state_r == ST_EXEC && !doneNow) [*5] ##1
      doneNow)
    else $error("table read timing wrong");
  AST_TICK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == ST_EXEC && phase_r == PHASE_LAST && !doneNow) |=>
      (phase_r == 2'h0) && (cyc_r == $past(cyc_r) + 2'h1))
    else $error("instruction cycle not four clocks");
  AST_NOP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (doneNow && op_r == OP_NOP) |=> $stable(acc_r) && $stable(statusVal) &&
      (pc_r == $past(pc_r) + PC_W'(1)))
    else $error("nop changed state");

endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the instruction execution core
`timescale 1ns/1ps
`define CHK(nm, xp, gt) \
  begin \
    checksDone++; \
    if ((gt) !== (xp)) \
    begin \
      errors++; \
      $display("ERROR %s expected %h seen %h", nm, xp, gt); \
    end \
  end
module tb_top;
  import cise_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, instrValid = 1'b0;
  logic instrReady, instrDone, progRd, powerDown, intEnable;
  cise_op_t opCode = OP_NOP;
  logic opToAcc = 0, opImm = 0, opLong = 0, wdtTimeout = 0, wakeUp = 0;
  logic [7:0] opAddr = 0, opData = 0, regWrData = 0, regRdData;
  logic [2:0] opBit = 0;
  logic [1:0] regAddr = 0;
  logic regWr = 0, regRd = 0;
  logic [PC_W-1:0] opTarget = 13'h0ABC, progAddr, pcOut;
  logic [15:0] progData;
  logic [7:0] a, b, st, s2, ac, mm, r;
  logic [12:0] e;
  logic cz, c;
  int errors = 0, checksDone = 0, cyc = 0, k, nRd = 0;
  integer seed = 32'hDECD;
  cise_op_t ops[7] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR};
  cise_op_t un[10] = '{OP_INC, OP_DEC, OP_CPL, OP_RR, OP_RL, OP_RRC,
                       OP_RLC, OP_SWAP, OP_SETB, OP_CLRB};
  assign progData = {3'h0, progAddr} ^ 16'hA5C3;
  always #25 clk_sys = ~clk_sys;
  cise_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .instrValid(instrValid), .instrReady(instrReady), .opCode(opCode),
    .opToAcc(opToAcc), .opImm(opImm), .opLong(opLong), .opAddr(opAddr),
    .opData(opData), .opBit(opBit), .opTarget(opTarget),
    .instrDone(instrDone), .progRd(progRd), .progAddr(progAddr),
    .progData(progData), .pcOut(pcOut), .powerDown(powerDown),
    .intEnable(intEnable), .wdtTimeout(wdtTimeout), .wakeUp(wakeUp),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData));
  task automatic print_verdict;
    if (errors == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (progRd === 1'b1)
      nRd++;
    if (cyc > 20000)
    begin
      errors++;
      print_verdict;
    end
  end
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    {regAddr, regWrData, regWr} <= {ad, d, 1'b1};
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [1:0] ad, output logic [7:0] d);
    {regAddr, regRd} <= {ad, 1'b1};
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdData;
    @(posedge clk_sys);
  endtask
  task automatic run(input cise_op_t op, input logic ta, im, lg,
    input logic [7:0] ad, dt, input logic [2:0] bt, input int nc);
    int n;
    {opCode, opToAcc, opImm, opLong, opAddr, opData, opBit}
      <= {op, ta, im, lg, ad, dt, bt};
    instrValid <= 1'b1;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (instrDone !== 1'b1 && n < 40);
    repeat (2) @(posedge clk_sys);
    `CHK("cycles", nc, n)
  endtask
  task automatic mw(input logic [7:0] ad, v, input logic lg);
    wr(REG_ACC, v);
    run(OP_MOVMA, 0, 0, lg, ad, 0, 0, lg ? 8 : 4);
  endtask
  task automatic mr(input logic [7:0] ad, input logic lg,
    output logic [7:0] v);
    run(OP_MOVAM, 1, 0, lg, ad, 0, 0, lg ? 8 : 4);
    rd(REG_ACC, v);
  endtask
  function automatic logic [12:0] addF(input logic [7:0] x, y,
    input logic ci);
    logic [8:0] s;
    logic ov;
    s = x + y + ci;
    ov = (x[7] == y[7]) && (s[7] != x[7]);
    return {ov ^ s[7], ov, s[7:0] == 8'h00,
      ({1'b0, x[3:0]} + y[3:0] + ci) > 5'h0F, s[8], s[7:0]};
  endfunction
  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(REG_STATUS, st);
    `CHK("status reset", 8'h00, st)
    for (int i = 0; i < 42; i++)
    begin
      {a, b} = 16'($random(seed));
      k = i % 7;
      if (!i[3]) mw(8'h11, b, 0);
      rd(REG_STATUS, st);
      wr(REG_ACC, a);
      e = (k == 0) ? addF(a, b, 0) : (k == 1) ? addF(a, b, st[0]) :
          (k == 2) ? addF(a, ~b, 1) : addF(a, ~b, st[0]);
      r = (k == 4) ? a & b : (k == 5) ? a | b : a ^ b;
      cz = (k == 2) ? e[10] : (k == 3) ? st[5] & e[10] : st[5];
      run(ops[k], 1, i[3], 0, 8'h11, b, 0, 4);
      rd(REG_ACC, ac);
      rd(REG_STATUS, s2);
      if (k < 4)
      begin
        `CHK("arith acc", e[7:0], ac)
        `CHK("arith flags", {st[7:6], cz, e[12:8]}, s2)
      end
      else
      begin
        `CHK("logic acc", r, ac)
        `CHK("logic flags", {st[7:3], r == 8'h00, st[1:0]}, s2)
      end
    end
    for (int i = 0; i < 20; i++)
    begin
      mm = 8'($random(seed));
      mw(8'h13, mm, 0);
      rd(REG_STATUS, st);
      k = i % 10;
      {c, r} = {st[0], 8'h01 << i[2:0]};
      case (un[k])
        OP_INC: r = mm + 8'h01;
        OP_DEC: r = mm - 8'h01;
        OP_CPL: r = ~mm;
        OP_RR: r = {mm[0], mm[7:1]};
        OP_RL: r = {mm[6:0], mm[7]};
        OP_RRC: {r, c} = {st[0], mm};
        OP_RLC: {c, r} = {mm, st[0]};
        OP_SWAP: r = {mm[3:0], mm[7:4]};
        OP_SETB: r = mm | r;
        default: r = mm & ~r;
      endcase
      run(un[k], i > 9 && k < 8, 0, 0, 8'h13, 0, i[2:0], 4);
      rd(REG_STATUS, s2);
      rd(REG_ACC, ac);
      mr(8'h13, 0, b);
      `CHK("unary acc", (i > 9 && k < 8) ? r : mm, ac)
      `CHK("unary mem", (i > 9 && k < 8) ? mm : r, b)
      `CHK("unary flags", {st[7:3], k < 3 ? r == 8'h00 : st[2], st[1],
        k == 5 || k == 6 ? c : st[0]}, s2)
    end
    mw(8'h12, 8'h3C, 0);
    run(OP_ADD, 0, 0, 0, 8'h12, 0, 0, 4);
    rd(REG_ACC, ac);
    `CHK("addm acc", 8'h3C, ac)
    mr(8'h12, 0, b);
    `CHK("addm mem", 8'h78, b)
    wr(REG_ACC, 8'h38);
    run(OP_ADD, 1, 1, 0, 8'h00, 8'h69, 0, 4);
    run(OP_DAA, 0, 0, 0, 8'h17, 0, 0, 4);
    rd(REG_STATUS, st);
    `CHK("bcd carry", 1'b1, st[0])
    rd(REG_ACC, ac);
    `CHK("bcd acc", 8'hA1, ac)
    mr(8'h17, 0, b);
    `CHK("bcd mem", 8'h07, b)
    mw(8'hA0, 8'h5A, 1);
    mw(8'hA0, 8'hC3, 0);
    mr(8'hA0, 1, b);
    `CHK("long mem", 8'h5A, b)
    mr(8'h20, 0, b);
    `CHK("sector0 mem", 8'hC3, b)
    run(OP_JMP, 0, 0, 0, 0, 0, 0, 8);
    `CHK("jump pc", 13'h0ABC, pcOut)
    repeat (3) run(OP_CALL, 0, 0, 0, 0, 0, 0, 8);
    run(OP_RET, 0, 0, 0, 0, 0, 0, 8);
    `CHK("return pc", 13'h0ABD, pcOut)
    run(OP_RETAX, 0, 0, 0, 0, 8'h5E, 0, 8);
    rd(REG_ACC, ac);
    `CHK("return acc", 8'h5E, ac)
    run(OP_INTERRUPT_RETURN_OP, 0, 0, 0, 0, 0, 0, 8);
    `CHK("int enable", 1'b1, intEnable)
    wr(REG_ACC, 8'h40);
    run(OP_MOVMA, 0, 0, 0, PCL_ADDR, 0, 0, 8);
    `CHK("pcl jump", 8'h40, pcOut[7:0])
    mw(8'h15, 8'h00, 0);
    run(OP_SZ, 0, 0, 0, 8'h15, 0, 0, 8);
    run(OP_SNZ, 0, 0, 0, 8'h15, 0, 0, 4);
    run(OP_SZ, 0, 0, 1, 8'h15, 0, 0, 12);
    run(OP_SDZ, 0, 0, 0, 8'h15, 0, 0, 4);
    run(OP_SIZ, 0, 0, 0, 8'h15, 0, 0, 8);
    mr(8'h15, 0, b);
    `CHK("skip inc mem", 8'h00, b)
    run(OP_SETM, 0, 0, 0, 8'h15, 0, 0, 4);
    run(OP_SZB, 0, 0, 0, 8'h15, 0, 3'h2, 4);
    run(OP_SNZB, 0, 0, 0, 8'h15, 0, 3'h2, 8);
    run(OP_SZA, 1, 0, 0, 8'h15, 0, 0, 4);
    rd(REG_ACC, ac);
    `CHK("skip move acc", 8'hFF, ac)
    run(OP_CLRM, 0, 0, 0, 8'h15, 0, 0, 4);
    mr(8'h15, 0, b);
    `CHK("clear mem", 8'h00, b)
    run(OP_NOP, 0, 0, 0, 0, 0, 0, 4);
    wr(REG_TABLE_POINTER, 8'h05);
    run(OP_ITRD, 0, 0, 0, 8'h16, 8'h02, 0, 8);
    `CHK("table addr", 13'h0206, progAddr)
    rd(REG_TABLE_HIGH_BYTE, ac);
    `CHK("table high", 8'hA7, ac)
    mr(8'h16, 0, b);
    `CHK("table low", 8'hC5, b)
    run(OP_TRDL, 0, 0, 0, 8'h16, 0, 0, 8);
    `CHK("last page", 13'h1F06, progAddr)
    `CHK("table strobes", 2, nRd)
    wdtTimeout <= 1'b1;
    @(posedge clk_sys);
    wdtTimeout <= 1'b0;
    run(OP_HALT, 0, 0, 0, 0, 0, 0, 4);
    `CHK("halt ready", 1'b0, instrReady)
    rd(REG_STATUS, st);
    `CHK("halt flags", 2'b01, st[7:6])
    wakeUp <= 1'b1;
    @(posedge clk_sys);
    wakeUp <= 1'b0;
    @(posedge clk_sys);
    `CHK("wake", 1'b0, powerDown)
    run(OP_CLRWDT, 0, 0, 0, 0, 0, 0, 4);
    rd(REG_STATUS, st);
    `CHK("wdt flags", 2'b00, st[7:6])
    print_verdict;
  end
endmodule
